/* File: sfr_regs.vh */
/*
 * Register offsets, field positions, reset values and timing counts
 * for the sensor fault response block.
 * Assumes a 32-bit APB with word-aligned registers and a 200 MHz pclk.
 */
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SFR_CTRL_OFS        12'h000
`define SFR_STAT_OFS        12'h004
`define SFR_IRQ_STAT_OFS    12'h008
`define SFR_IRQ_MASK_OFS    12'h00C
`define SFR_RESP_OFS        12'h010

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SFR_CTRL_ST_REQ     0
`define SFR_CTRL_RST        32'h0000_0000

// ----------------------------------------------------------------
// Response status word bit positions
// ----------------------------------------------------------------
`define SFR_RESP_IERR_BIT   1
`define SFR_RESP_ST_BIT     5
`define SFR_RESP_CAPLO_BIT  6

// ----------------------------------------------------------------
// Command codes and acceleration data select
// ----------------------------------------------------------------
`define SFR_CMD_REVINIT     4'hF
`define SFR_ACC_NORMAL      2'h0
`define SFR_ACC_ZERO        2'h1
`define SFR_ACC_SELFTEST    2'h2

// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define SFR_IRQ_REG_UV      0
`define SFR_IRQ_CAP_RST     1
`define SFR_IRQ_CAPTEST     2
`define SFR_IRQ_FRAME_TO    3
`define SFR_IRQ_CAP_LOW     4
`define SFR_IRQ_FUSE        5
`define SFR_IRQ_DROP        6
`define SFR_IRQ_W           7

// ----------------------------------------------------------------
// Timing, in ns, and derived cycle counts at 200 MHz
// ----------------------------------------------------------------
`define SFR_CLK_NS              5
`define SFR_SWITCH_OPEN_NS      20
`define SFR_SWITCH_OPEN_CYC     (`SFR_SWITCH_OPEN_NS / `SFR_CLK_NS)
`define SFR_CAP_TIMEOUT_NS      1000000
`define SFR_CAP_TIMEOUT_CYC     (`SFR_CAP_TIMEOUT_NS / `SFR_CLK_NS)
`define SFR_CAPTEST_PERIOD_NS   1000000
`define SFR_CAPTEST_PERIOD_CYC  (`SFR_CAPTEST_PERIOD_NS / `SFR_CLK_NS)
`define SFR_FRAME_TO_NS         1000000
`define SFR_FRAME_TO_CYC        (`SFR_FRAME_TO_NS / `SFR_CLK_NS)
`define SFR_RST_PULSE_CYC       4

`endif

/* File: sfr_fault_response.v */
/*
 * Exception manager of the satellite sensor: ranks fault inputs, drives
 * the internal reset, holds back responses, opens the bus switch and
 * builds the status flags and acceleration data selection.
 * Assumes fault inputs are already synchronous to pclk and that an APB
 * master reaches the registers.
 */
// Implementation choices: register access over APB and the placing of the registers.
// Function
// - Commands with identifier 1111 are dropped with no response.
// - Commands arriving on the downstream bus pin are ignored.
// - Regulator under-voltage holds reset and blocks all responses.
// - Any reset-class fault opens the bus switch within switch_open_time.
// - Cap dip, self-test off: flags 0,0,1; short reads zero, long normal.
// - Cap dip, self-test on: flags 0,1,1; all reads return self-test data.
// - Cap recovery before timeout keeps configuration.
// - Cap low past timeout resets, repeated each timeout period.
// - Capacitor test failure resets once per cap_test_reset_period.
// - Upstream bus low past frame timeout resets, repeated each period.
// - Fuse CRC fault, self-test off: flags 1,0,0; short zero, long normal.
// - Status word carries self-test bit 5, cap-low bit 6, error bit 1, bit 0 zero.
`include "sfr_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module sfr_fault_response (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        digital_regulator_uv,
    input  wire        analog_regulator_uv,
    input  wire        reserve_cap_low,
    input  wire        cap_test_fail,
    input  wire        upstream_bus_low,
    input  wire        fuse_crc_fail,
    input  wire        cmd_valid,
    input  wire        cmd_from_downstream,
    input  wire [3:0]  cmd_id,
    output reg         cmd_accept,
    output reg         resp_enable,
    output reg         bus_switch_close,
    output reg         device_reset,
    output reg  [1:0]  short_acc_sel,
    output reg  [1:0]  long_acc_sel,
    output reg  [7:0]  resp_status,
    output reg         irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function timer_done;
        input [31:0] count;
        input [31:0] limit;
        begin
            timer_done = (count >= limit - 32'h0000_0001);
        end
    endfunction

    function write_hit;
        input        strobe;
        input [11:0] addr;
        input [11:0] target;
        begin
            write_hit = strobe & (addr == target);
        end
    endfunction

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam [31:0] RST_LAST_CYC = `SFR_RST_PULSE_CYC - 1;
    localparam [31:0] OPEN_CYC     = `SFR_SWITCH_OPEN_CYC;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [31:0]           ctrl_reg;
    reg  [`SFR_IRQ_W-1:0] irq_stat_reg;
    reg  [`SFR_IRQ_W-1:0] irq_mask_reg;
    reg  [31:0]           cap_cnt_reg;
    reg  [31:0]           test_cnt_reg;
    reg  [31:0]           frame_cnt_reg;
    reg  [2:0]            rst_cnt_reg;
    reg                   rst_active_reg;
    reg  [2:0]            open_cnt_reg;
    reg                   cap_low_d_reg;
    reg                   fuse_d_reg;

    wire        selftest_active_flag;
    wire        reg_uv;
    wire        cap_expired;
    wire        test_expired;
    wire        frame_expired;
    wire        reset_pulse;
    wire        reset_class;
    wire        flag_fault;
    wire        drop_cmd;
    wire        wr_en;
    wire        rd_en;
    wire [`SFR_IRQ_W-1:0] irq_events;
    reg  [1:0]  short_sel_next;
    reg  [1:0]  long_sel_next;
    reg  [7:0]  status_next;
    reg  [31:0] rdata_next;
    reg         err_next;

    assign selftest_active_flag = ctrl_reg[`SFR_CTRL_ST_REQ];
    assign reg_uv = digital_regulator_uv | analog_regulator_uv;

    // ------------------------------------------------------------
    // Fault timers
    // ------------------------------------------------------------
    assign cap_expired   = reserve_cap_low &
                           timer_done(cap_cnt_reg, `SFR_CAP_TIMEOUT_CYC);
    assign test_expired  = cap_test_fail &
                           timer_done(test_cnt_reg, `SFR_CAPTEST_PERIOD_CYC);
    assign frame_expired = upstream_bus_low &
                           timer_done(frame_cnt_reg, `SFR_FRAME_TO_CYC);

    // Each expiry restarts its timer, so reset repeats every period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_cnt_reg   <= 32'h0000_0000;
            test_cnt_reg  <= 32'h0000_0000;
            frame_cnt_reg <= 32'h0000_0000;
        end else begin
            if (!reserve_cap_low || reg_uv || cap_expired)
                cap_cnt_reg <= 32'h0000_0000;
            else
                cap_cnt_reg <= cap_cnt_reg + 32'h0000_0001;
            if (!cap_test_fail || test_expired)
                test_cnt_reg <= 32'h0000_0000;
            else
                test_cnt_reg <= test_cnt_reg + 32'h0000_0001;
            if (!upstream_bus_low || reg_uv || frame_expired)
                frame_cnt_reg <= 32'h0000_0000;
            else
                frame_cnt_reg <= frame_cnt_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Reset generation
    // ------------------------------------------------------------
    assign reset_pulse = cap_expired | test_expired | frame_expired;
    // Reset-class faults outrank flag-only faults
    assign reset_class = reg_uv | rst_active_reg | reset_pulse;
    assign flag_fault  = ~reset_class & (reserve_cap_low | fuse_crc_fail);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_reg    <= 3'h0;
            rst_active_reg <= 1'b0;
        end else if (reset_pulse) begin
            rst_cnt_reg    <= 3'h0;
            rst_active_reg <= 1'b1;
        end else if (rst_active_reg) begin
            rst_cnt_reg <= rst_cnt_reg + 3'h1;
            if (rst_cnt_reg == RST_LAST_CYC[2:0])
                rst_active_reg <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_reset     <= 1'b1;
            resp_enable      <= 1'b0;
            bus_switch_close <= 1'b0;
            open_cnt_reg     <= 3'h0;
        end else begin
            device_reset <= reset_class;
            resp_enable  <= ~reset_class;
            // Switch opens on the next edge, well inside switch_open_time
            if (reset_class) begin
                bus_switch_close <= 1'b0;
                open_cnt_reg     <= OPEN_CYC[2:0];
            end else if (open_cnt_reg != 3'h0) begin
                open_cnt_reg <= open_cnt_reg - 3'h1;
            end else begin
                // Stays open until the master re-initializes the chain
                bus_switch_close <= ctrl_reg[1];
            end
        end
    end

    // ------------------------------------------------------------
    // Command filter
    // ------------------------------------------------------------
    assign drop_cmd = cmd_from_downstream |
                      (cmd_id == `SFR_CMD_REVINIT) |
                      reset_class;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cmd_accept <= 1'b0;
        else
            cmd_accept <= cmd_valid & ~drop_cmd;
    end

    // ------------------------------------------------------------
    // Flags and acceleration data selection
    // ------------------------------------------------------------
    always @* begin
        status_next    = 8'h00;
        short_sel_next = `SFR_ACC_NORMAL;
        long_sel_next  = `SFR_ACC_NORMAL;
        status_next[`SFR_RESP_ST_BIT] = selftest_active_flag;
        if (selftest_active_flag) begin
            short_sel_next = `SFR_ACC_SELFTEST;
            long_sel_next  = `SFR_ACC_SELFTEST;
        end
        if (flag_fault && reserve_cap_low) begin
            status_next[`SFR_RESP_CAPLO_BIT] = 1'b1;
            if (!selftest_active_flag)
                short_sel_next = `SFR_ACC_ZERO;
        end else if (flag_fault && fuse_crc_fail) begin
            status_next[`SFR_RESP_IERR_BIT] = 1'b1;
            short_sel_next = `SFR_ACC_ZERO;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_status   <= 8'h00;
            short_acc_sel <= `SFR_ACC_NORMAL;
            long_acc_sel  <= `SFR_ACC_NORMAL;
        end else begin
            resp_status   <= status_next;
            short_acc_sel <= short_sel_next;
            long_acc_sel  <= long_sel_next;
        end
    end

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_low_d_reg <= 1'b0;
            fuse_d_reg    <= 1'b0;
        end else begin
            cap_low_d_reg <= reserve_cap_low;
            fuse_d_reg    <= fuse_crc_fail;
        end
    end

    assign irq_events = {cmd_valid & drop_cmd,
                         fuse_crc_fail & ~fuse_d_reg,
                         reserve_cap_low & ~cap_low_d_reg,
                         frame_expired,
                         test_expired,
                         cap_expired,
                         reg_uv};

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;

    always @* begin
        rdata_next = 32'h0000_0000;
        err_next   = 1'b0;
        if (paddr == `SFR_CTRL_OFS)
            rdata_next = ctrl_reg;
        else if (paddr == `SFR_STAT_OFS)
            rdata_next = {26'h0, bus_switch_close, flag_fault,
                          resp_enable, device_reset, reset_pulse, reg_uv};
        else if (paddr == `SFR_IRQ_STAT_OFS)
            rdata_next = {25'h0, irq_stat_reg};
        else if (paddr == `SFR_IRQ_MASK_OFS)
            rdata_next = {25'h0, irq_mask_reg};
        else if (paddr == `SFR_RESP_OFS)
            rdata_next = {20'h0, long_acc_sel, short_acc_sel, resp_status};
        else
            err_next = 1'b1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & err_next;
            if (rd_en)
                prdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= {`SFR_IRQ_W{1'b0}};
            irq_mask_reg <= {`SFR_IRQ_W{1'b0}};
        end else begin
            // Set wins over write-one-to-clear
            if (write_hit(wr_en & pready, paddr, `SFR_IRQ_STAT_OFS))
                irq_stat_reg <= (irq_stat_reg & ~pwdata[`SFR_IRQ_W-1:0]) | irq_events;
            else
                irq_stat_reg <= irq_stat_reg | irq_events;
            if (write_hit(wr_en & pready, paddr, `SFR_IRQ_MASK_OFS))
                irq_mask_reg <= pwdata[`SFR_IRQ_W-1:0];
        end
    end

    // Reset-class faults drop configuration; cap dips keep it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_reg <= `SFR_CTRL_RST;
        else if (reset_class)
            ctrl_reg <= `SFR_CTRL_RST;
        else if (write_hit(wr_en & pready, paddr, `SFR_CTRL_OFS))
            ctrl_reg <= {30'h0, pwdata[1:0]};
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_reg & irq_mask_reg);
    end

endmodule

`default_nettype wire

/* File: sfr_fault_response_asserts.sv */
/* Checker for the fault response block, bound to its top module.
   Assumes one pclk domain with presetn as asynchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module sfr_fault_response_asserts (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       cmd_valid,
    input wire logic       cmd_from_downstream,
    input wire logic [3:0] cmd_id,
    input wire logic       cmd_accept,
    input wire logic       digital_regulator_uv,
    input wire logic       analog_regulator_uv,
    input wire logic       reserve_cap_low,
    input wire logic       cap_test_fail,
    input wire logic       upstream_bus_low,
    input wire logic       fuse_crc_fail,
    input wire logic       resp_enable,
    input wire logic       bus_switch_close,
    input wire logic       device_reset,
    input wire logic [1:0] short_acc_sel,
    input wire logic [7:0] resp_status
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire uv  = digital_regulator_uv | analog_regulator_uv;
    wire flt = uv | cap_test_fail | upstream_bus_low;
    a_revinit_drop: assert property (cmd_valid && cmd_id == 4'hF |=> !cmd_accept)
        else $error("reverse init command accepted");
    a_downstream_drop: assert property (cmd_valid && cmd_from_downstream |=> !cmd_accept)
        else $error("downstream command accepted");
    a_uv_reset_hold: assert property (uv |=> device_reset && !resp_enable && !cmd_accept)
        else $error("under-voltage without reset hold");
    a_switch_open: assert property (uv |-> ##[1:4] !bus_switch_close)
        else $error("bus switch not opened in time");
    a_cmd_accept: assert property (cmd_valid && !cmd_from_downstream
        && cmd_id != 4'hF && !flt && !device_reset |=> cmd_accept || device_reset)
        else $error("valid command not accepted");
    a_cap_flags: assert property (reserve_cap_low && !flt && !fuse_crc_fail
        && !device_reset |=> device_reset
        || (resp_status[6] && !resp_status[1] && short_acc_sel != 2'h0))
        else $error("cap dip flags wrong");
    a_fuse_flags: assert property (fuse_crc_fail && !flt && !reserve_cap_low
        && !device_reset |=> resp_status[1] && !resp_status[6] && short_acc_sel == 2'h1)
        else $error("fuse fault flags wrong");
    a_status_unused: assert property ((resp_status & 8'h9D) == 8'h00)
        else $error("unused status bits set");
endmodule
bind sfr_fault_response sfr_fault_response_asserts i_chk (.pclk, .presetn, .cmd_valid,
    .cmd_from_downstream, .cmd_id, .cmd_accept, .digital_regulator_uv, .analog_regulator_uv,
    .reserve_cap_low, .cap_test_fail, .upstream_bus_low, .fuse_crc_fail, .resp_enable,
    .bus_switch_close, .device_reset, .short_acc_sel, .resp_status);
`default_nettype wire

/* File: sfr_dsi_master.sv */
/* Bus master model: issues decoded commands to the block.
   Assumes commands are single-cycle strobes qualified by id and pin. */
`timescale 1ns/100ps
`default_nettype none
module sfr_dsi_master (
    input  wire logic       pclk,
    input  wire logic       cmd_accept,
    output var  logic       cmd_valid,
    output var  logic       cmd_from_downstream,
    output var  logic [3:0] cmd_id
);
    initial begin
        cmd_valid = 1'b0;
        cmd_from_downstream = 1'b0;
        cmd_id = 4'h0;
    end
    // Idle id is inverted so a stale value is never mistaken for a command
    task automatic send(input logic ds, input logic [3:0] id, output logic acc);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_from_downstream <= ds;
        cmd_id <= id;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        cmd_id <= ~id;
        @(posedge pclk);
        acc = cmd_accept;
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
/* Self-checking bench of the fault response block.
   Assumes APB register map of sfr_regs.vh and a 200 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
`include "sfr_regs.vh"
module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0]  flt = 6'h00;
    wire  [31:0] prdata;
    wire         pready, pslverr, cmd_accept, resp_enable, bus_switch_close;
    wire         device_reset, irq, cmd_valid, cmd_from_downstream;
    wire  [3:0]  cmd_id;
    wire  [1:0]  short_acc_sel, long_acc_sel;
    wire  [7:0]  resp_status;
    logic [31:0] rd;
    logic        rd_err, acc;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;
    always #2.5 pclk = ~pclk;
    sfr_fault_response i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .digital_regulator_uv(flt[0]),
        .analog_regulator_uv(flt[1]), .reserve_cap_low(flt[2]), .cap_test_fail(flt[3]),
        .upstream_bus_low(flt[4]), .fuse_crc_fail(flt[5]), .cmd_valid, .cmd_from_downstream,
        .cmd_id, .cmd_accept, .resp_enable, .bus_switch_close, .device_reset, .short_acc_sel,
        .long_acc_sel, .resp_status, .irq);
    sfr_dsi_master i_master (.pclk, .cmd_accept, .cmd_valid, .cmd_from_downstream, .cmd_id);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    task automatic t_regs;
        apb(1'b0, `SFR_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        chk(resp_status, 8'h00);
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        chk(rd_err, 1'b1);
        apb(1'b0, 12'h100, 32'h0);
        chk({rd_err, rd[7:0]}, 9'h100);
        $display("test regs done");
    endtask
    task automatic t_cmds;
        for (int i = 0; i < 16; i++) begin
            i_master.send(1'b0, 4'(i), acc);
            chk(acc, i != 15);
        end
        i_master.send(1'b1, 4'h3, acc);
        chk(acc, 1'b0);
        $display("test commands done");
    endtask
    task automatic t_uv;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, `SFR_CTRL_OFS, 32'h2);
            cyc(2);
            chk(bus_switch_close, 1'b1);
            flt[k] <= 1'b1;
            cyc(5);
            chk({device_reset, resp_enable}, 2'b10);
            chk(bus_switch_close, 1'b0);
            i_master.send(1'b0, 4'h1, acc);
            chk(acc, 1'b0);
            flt[k] <= 1'b0;
            cyc(3);
            apb(1'b0, `SFR_CTRL_OFS, 32'h0);
            chk(rd, 32'h0);
        end
        $display("test under-voltage done");
    endtask
    task automatic t_cap;
        apb(1'b1, `SFR_CTRL_OFS, 32'h2);
        flt[2] <= 1'b1;
        cyc(3);
        chk(resp_status, 8'h40);
        chk({short_acc_sel, long_acc_sel}, 4'h4);
        apb(1'b1, `SFR_CTRL_OFS, 32'h3);
        cyc(3);
        chk(resp_status, 8'h60);
        chk({short_acc_sel, long_acc_sel}, 4'hA);
        flt[2] <= 1'b0;
        cyc(3);
        apb(1'b0, `SFR_CTRL_OFS, 32'h0);
        chk(rd, 32'h3);
        chk(bus_switch_close, 1'b1);
        $display("test cap dip done");
    endtask
    task automatic t_fuse;
        apb(1'b1, `SFR_CTRL_OFS, 32'h2);
        apb(1'b1, `SFR_IRQ_MASK_OFS, 32'h0);
        apb(1'b1, `SFR_IRQ_STAT_OFS, 32'hFF);
        chk(irq, 1'b0);
        flt[5] <= 1'b1;
        cyc(3);
        chk(resp_status, 8'h02);
        chk({short_acc_sel, long_acc_sel}, 4'h4);
        chk(irq, 1'b0);
        apb(1'b1, `SFR_IRQ_MASK_OFS, 32'h20);
        cyc(2);
        chk(irq, 1'b1);
        flt[5] <= 1'b0;
        apb(1'b1, `SFR_IRQ_STAT_OFS, 32'h20);
        cyc(2);
        chk(irq, 1'b0);
        apb(1'b0, `SFR_IRQ_STAT_OFS, 32'h0);
        chk(rd[5], 1'b0);
        $display("test fuse done");
    endtask
    initial begin
        cyc(16);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_cmds();
        t_uv();
        t_cap();
        t_fuse();
        end_sim();
    end
endmodule
`default_nettype wire
